/* design/eeprom_autoload_cfg.svh */
`ifndef EEPROM_AUTOLOAD_CFG_SVH
`define EEPROM_AUTOLOAD_CFG_SVH
// register map (byte addresses on the plain port)
`define REG_ROM_CTRL 8'h00
`define REG_ROM_DATA 8'h04
`define REG_AUTOLOAD_STATUS 8'hDC
`define LOADED_BASE 8'h40
// control and status field positions
`define CTRL_START_BIT 0
`define CTRL_WRITE_BIT 1
`define CTRL_ADDR_LSB 8
`define STATUS_BUSY_BIT 3
// rom layout
`define ROM_SIGNATURE 16'h1516
`define ROM_WORD_SIG 7'h00
`define ROM_WORD_FIRST 7'h01
`define ROM_WORD_LAST 7'h0F
`define ROM_DEV_ADDR 7'h50
// timing: quarter-bit tick period in link clocks, minus one
`define SCL_HALF_CYCLES 8'h04
// rom internal write time in quarter bits; plain default, rom dependent
`define ROM_WRITE_WAIT 8'h40
`endif

/* design/eeprom_autoload_pkg.sv */
`default_nettype none
package eeprom_autoload_pkg;
    typedef enum logic [3:0] {
        L_IDLE, L_START, L_BITS, L_ACK, L_RESTART, L_READ, L_MACK, L_STOP, L_DONE
    } link_state_e;
    typedef enum logic [2:0] {
        S_BOOT, S_SIG, S_LOAD, S_IDLE, S_USER
    } seq_state_e;
endpackage : eeprom_autoload_pkg
`default_nettype wire

/* design/eeprom_autoload_sequencer.sv */
// Operation
// RL1: two pins to the rom: driven clock, shared data line.
// RL2: rom is 512 by 8 bits.
// RL3: load rom contents into registers after fundamental reset release.
// RL4: rom seen as 16-bit words with a 7-bit word address.
// RL5: rom address straps tied zero; only that device address is used.
// RL6: auto mode performs one whole-word read or write on request.
// RL7: start, word address and read/write selector in a register.
// RL8: software polls busy status before each new start.
// RL9: word zero is compared with the signature at reset.
// RL10: matching signature starts autoload right after reset release.
// RL11: consecutive words written into their mapped registers.
// RL12: bit 3 at DCh reads 1 while loading, 0 when done.
// RL13: host waits for status zero before other register access.
// RL14: words 10h, 12h, 14h give training, ppm, scramble for ports 0-2.
// RL15: words 18h, 1Ah, 1Ch give physical-layer sets 0,1 and bits 6:0 of 2.
// RL16: word 0Eh low byte is revision id, high byte ignored.
// RL17: separate management port: clock input and two-way data pin. The pins exist here but are not served; the data pin is never driven.
// RL18: signature mismatch skips autoload, keeps defaults, reports complete.
// RL19: start ignored while autoload or earlier access is in progress.
//
// The plain strobed port and the address map were decided locally.
`include "eeprom_autoload_cfg.svh"
`default_nettype none
module eeprom_autoload_sequencer
    import eeprom_autoload_pkg::*;
#(
    parameter int NUM_WORDS = 16
) (
    // system
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic fundamental_reset_n_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // loaded configuration
    output logic [7:0] revision_id_out,
    output logic [47:0] fast_training_cfg_out,
    output logic [47:0] phy_ctrl_out,
    output logic loading_out,
    // rom pins
    output logic rom_serial_clock_out,
    input wire logic rom_serial_data_in,
    output logic rom_serial_data_out,
    output logic rom_serial_data_oe_out,
    // management bus pins, not served by this block
    input wire logic mgmt_bus_clock_in,
    input wire logic mgmt_bus_data_in,
    output logic mgmt_bus_data_out,
    output logic mgmt_bus_data_oe_out
);
    ////////////////////////////////////////////////////////////////
    // system side
    logic [15:0] words_reg [NUM_WORDS];
    seq_state_e seq_reg;
    logic [6:0] waddr_reg;
    logic write_reg;
    logic [15:0] wword_reg;
    logic [15:0] rword_reg;
    logic busy_reg;
    logic req_tgl_reg;
    logic [2:0] done_sync_reg;
    logic [1:0] fundamental_reset_n_sync_reg;
    logic [15:0] link_word_reg;
    logic done_tgl_reg;
    logic done_seen;
    logic start_wr;
    logic [31:0] rd_mux;

    // reset release seen through two flops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) fundamental_reset_n_sync_reg <= 2'h0;
        else fundamental_reset_n_sync_reg <= {fundamental_reset_n_sync_reg[0], fundamental_reset_n_in};
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) done_sync_reg <= 3'h0;
        else done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
    end
    assign done_seen = done_sync_reg[2] ^ done_sync_reg[1];
    assign start_wr = wr_in && addr_in == `REG_ROM_CTRL && wdata_in[`CTRL_START_BIT];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seq_reg <= S_BOOT;
            waddr_reg <= 7'h00;
            write_reg <= 1'b0;
            wword_reg <= 16'h0000;
            rword_reg <= 16'h0000;
            busy_reg <= 1'b0;
            req_tgl_reg <= 1'b0;
        end else begin
            unique case (seq_reg)
                S_BOOT: if (fundamental_reset_n_sync_reg[1]) begin // RL3 RL10
                    seq_reg <= S_SIG;
                    waddr_reg <= `ROM_WORD_SIG; // RL9
                    write_reg <= 1'b0;
                    busy_reg <= 1'b1;
                    req_tgl_reg <= ~req_tgl_reg;
                end
                S_SIG: if (done_seen) begin
                    if (link_word_reg == `ROM_SIGNATURE) begin // RL9
                        seq_reg <= S_LOAD;
                        waddr_reg <= `ROM_WORD_FIRST;
                        req_tgl_reg <= ~req_tgl_reg;
                    end else begin
                        seq_reg <= S_IDLE; // RL18
                        busy_reg <= 1'b0;
                    end
                end
                S_LOAD: if (done_seen) begin // RL11
                    if (waddr_reg == `ROM_WORD_LAST) begin
                        seq_reg <= S_IDLE;
                        busy_reg <= 1'b0; // RL12
                    end else begin
                        waddr_reg <= waddr_reg + 7'h01;
                        req_tgl_reg <= ~req_tgl_reg;
                    end
                end
                S_IDLE: if (start_wr) begin // RL6 RL7
                    seq_reg <= S_USER;
                    waddr_reg <= wdata_in[`CTRL_ADDR_LSB +: 7]; // RL4
                    write_reg <= wdata_in[`CTRL_WRITE_BIT];
                    wword_reg <= wdata_in[31:16];
                    busy_reg <= 1'b1;
                    req_tgl_reg <= ~req_tgl_reg;
                end
                S_USER: if (done_seen) begin // RL19
                    seq_reg <= S_IDLE;
                    busy_reg <= 1'b0;
                    rword_reg <= link_word_reg;
                end
            endcase
        end
    end

    // loaded words; link word is stable when the done toggle arrives
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_WORDS; i++) words_reg[i] <= 16'h0000;
        end else if (seq_reg == S_LOAD && done_seen) begin
            words_reg[waddr_reg[3:0]] <= link_word_reg; // RL11
        end
    end

    // word map: 0Eh->7, 10h..14h->8..A, 18h..1Ch->C..E
    assign revision_id_out = words_reg[7][7:0]; // RL16
    assign fast_training_cfg_out = {words_reg[10], words_reg[9], words_reg[8]}; // RL14
    assign phy_ctrl_out = {words_reg[14] & 16'h007F, words_reg[13], words_reg[12]}; // RL15
    assign loading_out = busy_reg;

    logic sel_status;
    logic sel_ctrl;
    logic sel_data;
    logic sel_loaded;
    assign sel_status = addr_in == `REG_AUTOLOAD_STATUS;
    assign sel_ctrl = addr_in == `REG_ROM_CTRL;
    assign sel_data = addr_in == `REG_ROM_DATA;
    // loaded words at 40h..7Ch, word aligned only
    assign sel_loaded = addr_in[7:6] == 2'h1 && addr_in[1:0] == 2'h0;
    assign rd_mux = sel_status ? {28'h0, busy_reg, 3'h0} : // RL12
                    sel_ctrl ? {wword_reg, 1'b0, waddr_reg, 6'h0, write_reg, busy_reg} :
                    sel_data ? {16'h0, rword_reg} :
                    sel_loaded ? {16'h0, words_reg[addr_in[5:2]]} : 32'h0;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) rdata_out <= 32'h0;
        else if (rd_in) rdata_out <= rd_mux;
        else rdata_out <= 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    // link side: byte-addressed two-wire rom, word n at bytes 2n, 2n+1
    link_state_e lk_reg;
    logic [2:0] req_sync_reg;
    logic [7:0] div_reg;
    logic [1:0] ph_reg;
    logic [3:0] bit_reg;
    logic [2:0] byte_reg;
    logic [7:0] sh_reg;
    logic lk_write_reg;
    logic sda_reg;
    logic scl_reg;
    logic [1:0] sda_sync_reg;
    logic tick;
    logic req_seen;
    logic rd_data_reg;
    logic rx_byte;
    logic [7:0] wait_reg;
    logic oe_reg;

    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_sync_reg <= 3'h0;
            sda_sync_reg <= 2'h3;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
            sda_sync_reg <= {sda_sync_reg[0], rom_serial_data_in};
        end
    end
    assign req_seen = req_sync_reg[2] ^ req_sync_reg[1];
    assign tick = div_reg == `SCL_HALF_CYCLES;
    // data bytes of a read: line left to the rom, master acks only the first
    assign rx_byte = rd_data_reg && byte_reg >= 3'h2;

    // byte to send: 0 dev+w or dev+r, 1 addr, 2 data hi, 3 data lo
    function automatic logic [7:0] tx_byte(input logic [2:0] idx, input logic rd_phase);
        unique case (idx)
            3'h0: tx_byte = {`ROM_DEV_ADDR, rd_phase}; // RL5 RL2
            3'h1: tx_byte = {waddr_reg, 1'b0}; // RL4
            3'h2: tx_byte = wword_reg[15:8];
            default: tx_byte = wword_reg[7:0];
        endcase
    endfunction : tx_byte

    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lk_reg <= L_IDLE;
            div_reg <= 8'h00;
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            byte_reg <= 3'h0;
            sh_reg <= 8'h00;
            lk_write_reg <= 1'b0;
            sda_reg <= 1'b1;
            scl_reg <= 1'b1;
            link_word_reg <= 16'h0000;
            done_tgl_reg <= 1'b0;
            rd_data_reg <= 1'b0;
            wait_reg <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            unique case (lk_reg)
                L_IDLE: if (req_seen) begin
                    lk_reg <= L_START;
                    lk_write_reg <= write_reg;
                    byte_reg <= 3'h0;
                    rd_data_reg <= 1'b0;
                    wait_reg <= 8'h00;
                end
                L_START: if (tick) begin // RL1
                    sda_reg <= 1'b0;
                    sh_reg <= tx_byte(3'h0, 1'b0);
                    bit_reg <= 4'h0;
                    ph_reg <= 2'h0;
                    lk_reg <= L_BITS;
                end
                L_BITS: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) begin
                        scl_reg <= 1'b0;
                    end else if (ph_reg == 2'h1) begin
                        sda_reg <= rx_byte ? 1'b1 : sh_reg[7];
                    end else if (ph_reg == 2'h2) begin
                        scl_reg <= 1'b1;
                    end else begin
                        sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h7) lk_reg <= L_ACK;
                    end
                end
                L_ACK: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) scl_reg <= 1'b0;
                    else if (ph_reg == 2'h1) sda_reg <= !(rx_byte && byte_reg == 3'h2);
                    else if (ph_reg == 2'h2) scl_reg <= 1'b1;
                    else begin
                        byte_reg <= byte_reg + 3'h1;
                        bit_reg <= 4'h0;
                        if (byte_reg == 3'h1 && !lk_write_reg) begin
                            lk_reg <= L_RESTART;
                        end else if (byte_reg == 3'h3) begin
                            lk_reg <= L_STOP;
                        end else begin
                            sh_reg <= tx_byte(byte_reg + 3'h1, 1'b0);
                            lk_reg <= L_BITS;
                        end
                    end
                end
                L_RESTART: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) scl_reg <= 1'b0;
                    else if (ph_reg == 2'h1) sda_reg <= 1'b1;
                    else if (ph_reg == 2'h2) scl_reg <= 1'b1;
                    else begin
                        sda_reg <= 1'b0;
                        sh_reg <= tx_byte(3'h0, 1'b1);
                        byte_reg <= 3'h1;
                        lk_reg <= L_BITS;
                        lk_write_reg <= 1'b1;
                        rd_data_reg <= 1'b1;
                    end
                end
                L_READ, L_MACK: lk_reg <= L_IDLE;
                // rom ignores its bus while writing, so wait it out
                L_DONE: if (tick) begin
                    wait_reg <= wait_reg + 8'h01;
                    if (wait_reg == `ROM_WRITE_WAIT) begin
                        done_tgl_reg <= ~done_tgl_reg;
                        lk_reg <= L_IDLE;
                    end
                end
                L_STOP: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    if (ph_reg == 2'h0) scl_reg <= 1'b0;
                    else if (ph_reg == 2'h1) sda_reg <= 1'b0;
                    else if (ph_reg == 2'h2) scl_reg <= 1'b1;
                    else begin
                        sda_reg <= 1'b1;
                        if (rd_data_reg) begin
                            done_tgl_reg <= ~done_tgl_reg;
                            lk_reg <= L_IDLE;
                        end else begin
                            lk_reg <= L_DONE;
                        end
                    end
                end
            endcase
            // reads: bytes 2 and 3 after restart shift in the word
            if (lk_reg == L_ACK && tick && ph_reg == 2'h3 && byte_reg >= 3'h2)
                link_word_reg <= {link_word_reg[7:0], sh_reg};
        end
    end

    ////////////////////////////////////////////////////////////////
    // pins
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) oe_reg <= 1'b0;
        else oe_reg <= ~sda_reg;
    end
    // open-drain style: only drive low
    assign rom_serial_clock_out = scl_reg; // RL1
    assign rom_serial_data_out = 1'b0;
    assign rom_serial_data_oe_out = oe_reg;
    assign mgmt_bus_data_out = 1'b0; // RL17
    assign mgmt_bus_data_oe_out = 1'b0;
endmodule : eeprom_autoload_sequencer
`default_nettype wire

/* bench/eeprom_autoload_checker.sv */
`include "eeprom_autoload_cfg.svh"
`default_nettype none
module eeprom_autoload_checker #(
    parameter int NUM_WORDS = 16
) (
    // system and register port
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    // loaded outputs and pins
    input wire logic [7:0] revision_id_out,
    input wire logic [47:0] fast_training_cfg_out,
    input wire logic [47:0] phy_ctrl_out,
    input wire logic loading_out,
    input wire logic rom_serial_data_out,
    input wire logic mgmt_bus_data_out,
    input wire logic mgmt_bus_data_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_read(logic [7:0] a);
        rd_in && addr_in == a;
    endsequence
    sequence s_start;
        wr_in && addr_in == `REG_ROM_CTRL && wdata_in[`CTRL_START_BIT];
    endsequence
    ////////////////////////////////////////
    a_idle_read_zero: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero");
    a_status_busy_bit: assert property (s_read(8'hDC) |=> rdata_out[3] == $past(loading_out))
        else $error("status bit wrong");
    a_unmapped_reads_zero: assert property (rd_in && int'(addr_in) >= 64 + 4 * NUM_WORDS
        && addr_in != 8'hDC |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_revision_low_byte: assert property (s_read(8'h5C)
        |=> rdata_out[7:0] == $past(revision_id_out))
        else $error("revision mismatch");
    a_training_word: assert property (s_read(8'h60) |=> rdata_out[15:0]
        == $past(fast_training_cfg_out[15:0]))
        else $error("training word mismatch");
    a_phy_top_zero: assert property (phy_ctrl_out[47:39] == 9'h000)
        else $error("phy set 2 upper bits set");
    a_rom_open_drain: assert property (rom_serial_data_out == 1'b0)
        else $error("rom data driven high");
    a_mgmt_released: assert property (!mgmt_bus_data_oe_out && !mgmt_bus_data_out)
        else $error("management data driven");
    a_start_sets_busy: assert property (s_start and !loading_out |-> ##[1:6] loading_out)
        else $error("start did not raise busy");
    a_busy_min_hold: assert property ($rose(loading_out) |-> loading_out [*8])
        else $error("busy too short");
    a_start_while_busy: assert property (s_start and loading_out |=> loading_out)
        else $error("start while busy disturbed access");
endmodule : eeprom_autoload_checker
bind eeprom_autoload_sequencer eeprom_autoload_checker #(.NUM_WORDS(NUM_WORDS)) chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .revision_id_out(revision_id_out),
    .fast_training_cfg_out(fast_training_cfg_out), .phy_ctrl_out(phy_ctrl_out),
    .loading_out(loading_out), .rom_serial_data_out(rom_serial_data_out),
    .mgmt_bus_data_out(mgmt_bus_data_out), .mgmt_bus_data_oe_out(mgmt_bus_data_oe_out));
`default_nettype wire

/* bench/rom_model.sv */
`default_nettype none
module rom_model (
    // wire levels seen at the rom
    input wire logic scl_in,
    input wire logic sda_in,
    // high pulls the data line low
    output logic sda_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [512];
    logic [7:0] sh;
    logic [7:0] tx;
    logic [8:0] ptr;
    logic rd = 1'b0;
    int n = 0;
    int phase = 0;
    initial sda_oe_out = 1'b0;
    // start and stop both restart byte framing
    always @(sda_in) if (scl_in === 1'b1) begin
        n = 0;
        phase = 0;
        rd = 1'b0;
    end
    always @(posedge scl_in) begin
        if (n < 8) sh = {sh[6:0], sda_in};
        else if (rd && sda_in) rd = 1'b0;
        n = (n == 8) ? 0 : n + 1;
    end
    // drive only while clock low so no false start is seen
    always @(negedge scl_in) begin
        sda_oe_out <= 1'b0;
        if (n == 8 && !rd) begin
            if (phase == 0 && sh[7:2] == 6'b101000) begin
                ptr[8] = sh[1];
                rd = sh[0];
                phase = 1;
                sda_oe_out <= 1'b1;
            end else if (phase != 0) begin
                if (phase == 1) ptr[7:0] = sh;
                else mem[ptr] = sh;
                if (phase == 2) ptr = ptr + 9'h001;
                phase = 2;
                sda_oe_out <= 1'b1;
            end
        end else if (rd && n < 8) begin
            if (n == 0) tx = mem[ptr];
            if (n == 0) ptr = ptr + 9'h001;
            sda_oe_out <= !tx[7 - n];
        end
    end
endmodule : rom_model
`default_nettype wire

/* bench/tb_top.sv */
`include "eeprom_autoload_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic fundamental_reset_n = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [7:0] revision_id_out;
    logic [47:0] fast_training_cfg_out, phy_ctrl_out;
    logic loading_out, scl, sda_oe, sda_out, model_oe;
    wire logic sda = ~(sda_oe | model_oe);
    int errors = 0;
    int tests_run = 0;
    always #2.5 clk_in = ~clk_in;
    initial begin
        #1.3;
        forever #7.5 link_clk_in = ~link_clk_in;
    end
    eeprom_autoload_sequencer uut (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
        .fundamental_reset_n_in(fundamental_reset_n), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .revision_id_out(revision_id_out),
        .fast_training_cfg_out(fast_training_cfg_out), .phy_ctrl_out(phy_ctrl_out),
        .loading_out(loading_out), .rom_serial_clock_out(scl), .rom_serial_data_in(sda),
        .rom_serial_data_out(sda_out), .rom_serial_data_oe_out(sda_oe),
        .mgmt_bus_clock_in(1'b1), .mgmt_bus_data_in(1'b1), .mgmt_bus_data_out(),
        .mgmt_bus_data_oe_out());
    rom_model rom (.scl_in(scl), .sda_in(sda), .sda_oe_out(model_oe));
    ////////////////////////////////////////
    task automatic end_of_test();
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic chk(logic [47:0] got, logic [47:0] exp, string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    task automatic auto_op(logic [6:0] w, logic write, logic [15:0] d);
        wr(`REG_ROM_CTRL, {d, 1'b0, w, 6'h00, write, 1'b1});
    endtask : auto_op
    // poll rather than wait fixed time: rom timing is not ours
    task automatic wait_idle();
        logic [31:0] d;
        for (int i = 0; i < 40000; i++) begin
            rd(`REG_AUTOLOAD_STATUS, d);
            if (d[`STATUS_BUSY_BIT] === 1'b0) return;
        end
        errors++;
        end_of_test();
    endtask : wait_idle
    task automatic do_reset();
        rst_in <= 1'b1;
        fundamental_reset_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        fundamental_reset_n <= 1'b1;
        repeat (20) @(posedge clk_in);
    endtask : do_reset
    ////////////////////////////////////////
    task automatic t_autoload();
        logic [31:0] d;
        logic [15:0] w [16];
        for (int n = 0; n < 16; n++) w[n] = {rom.mem[2 * n], rom.mem[2 * n + 1]};
        rd(`REG_AUTOLOAD_STATUS, d);
        chk(d[3], 1'b1, "busy after reset");
        wait_idle();
        for (int n = 1; n < 16; n++) begin
            rd(8'(`LOADED_BASE + 4 * n), d);
            chk(d[7:0], w[n][7:0], "loaded low byte");
            if (n != 7) chk(d[15:8], w[n][15:8], "loaded high byte");
        end
        chk(revision_id_out, w[7][7:0], "revision");
        chk(fast_training_cfg_out, {w[10], w[9], w[8]}, "training");
        chk(phy_ctrl_out, {w[14] & 16'h007F, w[13], w[12]}, "phy");
    endtask : t_autoload
    task automatic t_auto_access();
        logic [31:0] d;
        auto_op(7'h7F, 1'b0, 16'h0000);
        auto_op(7'h11, 1'b0, 16'h0000);
        wait_idle();
        rd(`REG_ROM_DATA, d);
        chk(d[15:0], {rom.mem[254], rom.mem[255]}, "top word read");
        auto_op(7'h33, 1'b1, 16'hC3A5);
        wait_idle();
        chk({rom.mem[102], rom.mem[103]}, 16'hC3A5, "rom written");
        auto_op(7'h33, 1'b0, 16'h0000);
        wait_idle();
        rd(`REG_ROM_DATA, d);
        chk(d[15:0], 16'hC3A5, "read back");
        rd(8'h80, d);
        chk(d, 32'h0, "unmapped");
    endtask : t_auto_access
    task automatic t_mismatch();
        logic [31:0] d;
        rom.mem[1] = 8'h17;
        do_reset();
        wait_idle();
        rd(8'h5C, d);
        chk(d, 32'h0, "default kept");
        chk(fast_training_cfg_out, 48'h0, "training default");
    endtask : t_mismatch
    initial begin
        for (int i = 0; i < 512; i++) rom.mem[i] = 8'(i * 59) ^ 8'hA5;
        rom.mem[0] = 8'h15;
        rom.mem[1] = 8'h16;
        do_reset();
        t_autoload();
        t_auto_access();
        t_mismatch();
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
